// ### src/sbet_pkg.sv
// Purpose: Shared constants and carrier types for the sideband error and thermal block.
// Assumes: One 200 MHz clock; the reference clock rate is a named constant.
// Notes: Counts are derived from times so a change of rate stays consistent.
package sbet_pkg;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int unsigned SBET_CLK_MHZ = 200;
    localparam int unsigned SBET_REF_MHZ = 100;
    localparam int unsigned SBET_PULSE_REF_CYCLES = 16;
    // Ratio of core clock to reference clock, at least one.
    localparam int unsigned SBET_REF_DIV = (SBET_CLK_MHZ / SBET_REF_MHZ) < 1 ? 1
        : (SBET_CLK_MHZ / SBET_REF_MHZ);
    localparam logic [7:0] SBET_REF_DIV_LAST = 8'(SBET_REF_DIV - 1);
    localparam logic [4:0] SBET_PULSE_LEN = 5'(SBET_PULSE_REF_CYCLES);

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int unsigned SBET_IO_CORR_BIT = 0;
    localparam int unsigned SBET_IO_NONFATAL_BIT = 1;
    localparam int unsigned SBET_IO_FATAL_BIT = 2;
    localparam logic [2:0] SBET_IO_STATUS_RST = 3'h0;
    localparam logic [1:0] SBET_THROTTLE_RST = 2'h0;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        SBET_FE_IDLE  = 3'b001,
        SBET_FE_PULSE = 3'b010,
        SBET_FE_HOLD  = 3'b100
    } sbet_fe_state_type;

    // One open-drain pin drive: out level, driven low when oe is high.
    typedef struct packed {
        logic oe;
        logic out;
    } sbet_od_type;

    typedef struct packed {
        logic corrected;
        logic nonfatal;
        logic fatal;
    } sbet_io_err_type;

endpackage

// ### src/sbet_refdiv.sv
// Purpose: Divides the core clock to one-cycle reference clock enables.
// Assumes: Synchronous active-low reset.
// Notes: Enable comes every SBET_REF_DIV core cycles.
`timescale 1ns/100ps
`default_nettype none
module sbet_refdiv
    import sbet_pkg::*;
(
    input wire logic i_clk, // Core clock.
    input wire logic i_nrst, // Synchronous reset, active low.
    output logic o_ref_en // One-cycle reference enable.
);
    logic [7:0] cnt_r;

    always_ff @(posedge i_clk)
    begin
        if (!i_nrst)
        begin
            cnt_r <= 8'h00;
            o_ref_en <= 1'b0;
        end
        else if (cnt_r == SBET_REF_DIV_LAST)
        begin
            cnt_r <= 8'h00;
            o_ref_en <= 1'b1;
        end
        else
        begin
            cnt_r <= cnt_r + 8'h01;
            o_ref_en <= 1'b0;
        end
    end
endmodule // sbet_refdiv
`default_nettype wire

// ### src/sbet_top.sv
// Purpose: Sideband error and thermal signalling of the device.
// Assumes: All inputs synchronous to i_clk; open-drain lines pulled up externally.
// Notes: Shared lines are seen as levels on i_*_n and driven low through o_*_oe.
// What this block does
// - Drive the shared fatal error line on any unrecoverable error.
// - External fatal error assertion raises a machine check, sampled after power good.
// - Machine check error class pulses the fatal line for 16 reference clocks.
// - Internal error class holds the fatal line until warm or cold reset.
// - Three-bit I/O error status: corrected, non-fatal, fatal.
// - Memory-hot input throttles the channels of that line.
// - Memory-hot output held while that memory branch is over temperature.
// - Pair a serves channels 0 and 1, pair b channels 2 and 3.
// - In enhanced mode, machine check exceptions go on the interrupt output.
// - Hub sends power management status on the sync input; device accepts it.
// - Drive overtemp line when the sensor reaches maximum safe temperature.
// - External overtemp assertion activates thermal control, sampled after power good.
// - Overtemp active at warm reset assertion tristates outputs.
`timescale 1ns/100ps
`default_nettype none
module sbet_top
    import sbet_pkg::*;
(
    input wire logic i_clk, // Core clock, 200 MHz.
    input wire logic i_nrst, // Synchronous reset, active low (warm or cold).
    input wire logic i_power_good_in, // Supplies and clocks stable.
    input wire logic i_mc_error_event, // One-cycle machine check error class event.
    input wire logic i_int_error_event, // One-cycle internal error class event.
    input wire sbet_io_err_type i_io_err, // I/O unit error status levels.
    input wire logic i_enh_mc_mode, // Enhanced machine check mode enable.
    input wire logic i_mem_hot_mode_out, // Memory-hot lines in output level mode.
    input wire logic [1:0] i_branch_overtemp, // Branch a/b over temperature.
    input wire logic i_sensor_overtemp, // Die at maximum safe temperature.
    input wire logic i_power_mgmt_sync_in, // Power management status from hub.
    input wire logic i_fatal_error_line_n, // Level seen on fatal error line.
    input wire logic i_memory_hot_pair_a_n, // Level seen on memory-hot pair a.
    input wire logic i_memory_hot_pair_b_n, // Level seen on memory-hot pair b.
    input wire logic i_processor_overtemp_line_n, // Level seen on overtemp line.
    output sbet_od_type o_fatal_error_line, // Fatal error line drive.
    output sbet_od_type o_memory_hot_pair_a, // Memory-hot pair a drive.
    output sbet_od_type o_memory_hot_pair_b, // Memory-hot pair b drive.
    output sbet_od_type o_processor_overtemp_line, // Overtemp line drive.
    output logic [2:0] o_io_error_n, // I/O unit error status, active low.
    output logic o_io_error_oe, // I/O status output enable.
    output logic o_machine_check_interrupt_out_n, // Machine check interrupt, active low.
    output logic o_machine_check_exception, // Machine check raised, one-cycle pulse.
    output logic [3:0] o_throttle_channel, // Memory channel throttle requests.
    output logic o_thermal_control_active, // Thermal control circuit active.
    output logic o_power_mgmt_status, // Accepted power management status.
    output logic o_outputs_tristated // Outputs released by warm-reset overtemp.
);
    // ------------------------------------------------------------------
    // Reference clock enable and power good tracking
    // ------------------------------------------------------------------
    logic ref_en;
    logic pg_r;
    logic rst_prev_r;
    logic tristate_r;
    logic [4:0] pulse_cnt_r;
    logic ext_fatal_prev_r;
    sbet_fe_state_type fe_state_r;
    sbet_fe_state_type fe_state_nxt;
    logic fe_drive;
    logic ext_fatal;
    logic ext_overtemp;

    sbet_refdiv u_refdiv (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .o_ref_en(ref_en)
    );

    always_ff @(posedge i_clk)
    begin
        if (!i_nrst)
            pg_r <= 1'b0;
        else
            pg_r <= i_power_good_in;
    end

    // ------------------------------------------------------------------
    // Warm-reset tristate strap
    // ------------------------------------------------------------------
    // Caught by the clock at the edge where reset is first seen low, while
    // power good is already high; a cold boot never tristates.
    always_ff @(posedge i_clk)
    begin
        rst_prev_r <= i_nrst;
        if (!i_power_good_in)
            tristate_r <= 1'b0;
        else if (rst_prev_r && !i_nrst)
            tristate_r <= !i_processor_overtemp_line_n;
    end

    // ------------------------------------------------------------------
    // Fatal error line sequencer
    // ------------------------------------------------------------------
    always_comb
    begin
        fe_state_nxt = fe_state_r;
        case (fe_state_r)
            SBET_FE_IDLE:
            begin
                if (i_int_error_event)
                    fe_state_nxt = SBET_FE_HOLD;
                else if (i_mc_error_event)
                    fe_state_nxt = SBET_FE_PULSE;
            end
            SBET_FE_PULSE:
            begin
                if (i_int_error_event)
                    fe_state_nxt = SBET_FE_HOLD;
                else if (ref_en && pulse_cnt_r == SBET_PULSE_LEN - 5'h01)
                    fe_state_nxt = SBET_FE_IDLE;
            end
            SBET_FE_HOLD:
                fe_state_nxt = SBET_FE_HOLD;
            default:
                fe_state_nxt = SBET_FE_IDLE;
        endcase
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_nrst)
            fe_state_r <= SBET_FE_IDLE;
        else
            fe_state_r <= fe_state_nxt;
    end

    // Counts reference clocks while the pulse stands.
    always_ff @(posedge i_clk)
    begin
        if (!i_nrst || fe_state_r != SBET_FE_PULSE)
            pulse_cnt_r <= 5'h00;
        else if (ref_en)
            pulse_cnt_r <= pulse_cnt_r + 5'h01;
    end

    assign fe_drive = fe_state_r != SBET_FE_IDLE;

    // Our own drive is excluded so the device does not trap on its own error.
    // The pin drive lags the state by one clock, so both are masked; otherwise
    // the last cycle of our own pulse would look like an outside assertion.
    assign ext_fatal = pg_r && !i_fatal_error_line_n && !fe_drive
        && !o_fatal_error_line.oe;
    assign ext_overtemp = pg_r && !i_processor_overtemp_line_n
        && !o_processor_overtemp_line.oe;

    always_ff @(posedge i_clk)
    begin
        if (!i_nrst)
        begin
            ext_fatal_prev_r <= 1'b0;
            o_machine_check_exception <= 1'b0;
        end
        else
        begin
            ext_fatal_prev_r <= ext_fatal;
            o_machine_check_exception <= (ext_fatal && !ext_fatal_prev_r)
                || i_mc_error_event;
        end
    end

    // ------------------------------------------------------------------
    // Pin drives
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk)
    begin
        if (!i_nrst)
        begin
            o_fatal_error_line <= '0;
            o_memory_hot_pair_a <= '0;
            o_memory_hot_pair_b <= '0;
            o_processor_overtemp_line <= '0;
            o_io_error_n <= ~SBET_IO_STATUS_RST;
            o_io_error_oe <= 1'b0;
            o_machine_check_interrupt_out_n <= 1'b1;
        end
        else
        begin
            // Shared lines only ever pull low.
            o_fatal_error_line <= '{oe: fe_drive && !tristate_r, out: 1'b0};
            o_memory_hot_pair_a <= '{oe: i_mem_hot_mode_out && i_branch_overtemp[0]
                && !tristate_r, out: 1'b0};
            o_memory_hot_pair_b <= '{oe: i_mem_hot_mode_out && i_branch_overtemp[1]
                && !tristate_r, out: 1'b0};
            o_processor_overtemp_line <= '{oe: i_sensor_overtemp && !tristate_r,
                out: 1'b0};
            o_io_error_n[SBET_IO_CORR_BIT] <= !i_io_err.corrected;
            o_io_error_n[SBET_IO_NONFATAL_BIT] <= !i_io_err.nonfatal;
            o_io_error_n[SBET_IO_FATAL_BIT] <= !i_io_err.fatal;
            o_io_error_oe <= !tristate_r;
            o_machine_check_interrupt_out_n <= !(i_enh_mc_mode
                && o_machine_check_exception);
        end
    end

    // ------------------------------------------------------------------
    // Throttle, thermal control and power management status
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk)
    begin
        if (!i_nrst)
        begin
            o_throttle_channel <= {SBET_THROTTLE_RST, SBET_THROTTLE_RST};
            o_thermal_control_active <= 1'b0;
            o_power_mgmt_status <= 1'b0;
        end
        else
        begin
            // Input mode only; in output mode the line reflects our own drive.
            o_throttle_channel[1:0] <= {2{!i_mem_hot_mode_out
                && !i_memory_hot_pair_a_n}};
            o_throttle_channel[3:2] <= {2{!i_mem_hot_mode_out
                && !i_memory_hot_pair_b_n}};
            o_thermal_control_active <= i_sensor_overtemp || ext_overtemp;
            o_power_mgmt_status <= i_power_mgmt_sync_in;
        end
    end

    assign o_outputs_tristated = tristate_r;
endmodule // sbet_top
`default_nettype wire

// ### tb/sbet_far_end.sv
// Purpose: Platform side of the shared open-drain sideband lines.
// Assumes: Bit order fatal line, memory-hot pair a, pair b, overtemp line.
// Notes: A released line reads high through its pull-up, never the last value.
`timescale 1ns/100ps
`default_nettype none
module sbet_far_end (
    input wire logic [3:0] i_dev_oe, // Device pull-downs.
    input wire logic [3:0] i_ext_pull, // Platform agent pull-downs.
    output logic [3:0] o_level_n // Resolved wire levels.
);
    // Any party pulling low wins, so every processor sees every assertion.
    assign o_level_n = ~(i_dev_oe | i_ext_pull);
endmodule // sbet_far_end
`default_nettype wire

// ### tb/sbet_top_sva.sv
// Purpose: Port-level timing checks of the sideband error and thermal block.
// Assumes: Bound to every sbet_top instance.
// Notes: Reset is synchronous, so every check pauses while i_nrst is low.
`timescale 1ns/100ps
`default_nettype none
module sbet_top_chk
    import sbet_pkg::*;
(
    input wire logic i_clk, // Clock.
    input wire logic i_nrst, // Reset.
    input wire logic i_mc_error_event, // Event.
    input wire logic i_int_error_event, // Event.
    input wire sbet_io_err_type i_io_err, // Status.
    input wire logic i_enh_mc_mode, // Mode.
    input wire logic i_mem_hot_mode_out, // Mode.
    input wire logic [1:0] i_branch_overtemp, // Branches.
    input wire logic i_sensor_overtemp, // Sensor.
    input wire logic i_power_mgmt_sync_in, // Hub.
    input wire logic i_memory_hot_pair_a_n, // Wire a.
    input wire logic i_memory_hot_pair_b_n, // Wire b.
    input wire sbet_od_type o_fatal_error_line, // Drive.
    input wire sbet_od_type o_memory_hot_pair_a, // Drive.
    input wire sbet_od_type o_memory_hot_pair_b, // Drive.
    input wire sbet_od_type o_processor_overtemp_line, // Drive.
    input wire logic [2:0] o_io_error_n, // Status.
    input wire logic o_io_error_oe, // Enable.
    input wire logic o_machine_check_interrupt_out_n, // Interrupt.
    input wire logic o_machine_check_exception, // Exception.
    input wire logic [3:0] o_throttle_channel, // Throttle.
    input wire logic o_thermal_control_active, // Thermal.
    input wire logic o_power_mgmt_status, // Status.
    input wire logic o_outputs_tristated // Released.
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_nrst);
    property p_fe_min;
        $rose(o_fatal_error_line.oe) |-> ##30 o_fatal_error_line.oe;
    endproperty
    a_fe_min: assert property (p_fe_min) else $error("fatal pulse too short");
    property p_int_hold;
        i_int_error_event |-> ##2 o_fatal_error_line.oe [*8];
    endproperty
    a_int_hold: assert property (p_int_hold) else $error("fatal hold lost");
    property p_mc_event;
        i_mc_error_event && !o_fatal_error_line.oe |=> o_machine_check_exception;
    endproperty
    a_mc_event: assert property (p_mc_event) else $error("no exception");
    property p_fe_drive;
        (i_mc_error_event || i_int_error_event) && !o_fatal_error_line.oe
            && !o_outputs_tristated |-> ##2 o_fatal_error_line.oe;
    endproperty
    a_fe_drive: assert property (p_fe_drive) else $error("fatal line not driven");
    property p_io;
        1'h1 |=> o_io_error_n == ~$past({i_io_err.fatal, i_io_err.nonfatal, i_io_err.corrected});
    endproperty
    a_io: assert property (p_io) else $error("io status wrong");
    property p_mem_out;
        i_mem_hot_mode_out ##1 !o_outputs_tristated
            |-> {o_memory_hot_pair_b.oe, o_memory_hot_pair_a.oe} == $past(i_branch_overtemp);
    endproperty
    a_mem_out: assert property (p_mem_out) else $error("memory-hot drive wrong");
    property p_throttle;
        !i_mem_hot_mode_out |=> o_throttle_channel
            == {{2{!$past(i_memory_hot_pair_b_n)}}, {2{!$past(i_memory_hot_pair_a_n)}}};
    endproperty
    a_throttle: assert property (p_throttle) else $error("throttle wrong");
    property p_int;
        o_machine_check_exception && i_enh_mc_mode |=> !o_machine_check_interrupt_out_n;
    endproperty
    a_int: assert property (p_int) else $error("no interrupt");
    property p_int_only;
        !o_machine_check_exception |=> o_machine_check_interrupt_out_n;
    endproperty
    a_int_only: assert property (p_int_only) else $error("stray interrupt");
    property p_hot;
        i_sensor_overtemp ##1 !o_outputs_tristated
            |-> o_processor_overtemp_line.oe && o_thermal_control_active;
    endproperty
    a_hot: assert property (p_hot) else $error("overtemp not driven");
    property p_pm;
        1'h1 |=> o_power_mgmt_status == $past(i_power_mgmt_sync_in);
    endproperty
    a_pm: assert property (p_pm) else $error("sync status lost");
    property p_tri;
        $past(o_outputs_tristated) && o_outputs_tristated |-> !o_io_error_oe
            && !(o_fatal_error_line.oe | o_memory_hot_pair_a.oe | o_memory_hot_pair_b.oe
            | o_processor_overtemp_line.oe);
    endproperty
    a_tri: assert property (p_tri) else $error("drive while released");
    c_pulse: cover property ($rose(o_fatal_error_line.oe));
    c_tri: cover property ($rose(o_outputs_tristated));
    c_thr: cover property (o_throttle_channel != 4'h0);
endmodule // sbet_top_chk
bind sbet_top sbet_top_chk u_sbet_top_chk (.i_clk, .i_nrst, .i_mc_error_event,
    .i_int_error_event, .i_io_err, .i_enh_mc_mode, .i_mem_hot_mode_out, .i_branch_overtemp,
    .i_sensor_overtemp, .i_power_mgmt_sync_in, .i_memory_hot_pair_a_n, .i_memory_hot_pair_b_n,
    .o_fatal_error_line, .o_memory_hot_pair_a, .o_memory_hot_pair_b, .o_processor_overtemp_line,
    .o_io_error_n, .o_io_error_oe, .o_machine_check_interrupt_out_n, .o_machine_check_exception,
    .o_throttle_channel, .o_thermal_control_active, .o_power_mgmt_status, .o_outputs_tristated);
`default_nettype wire

// ### tb/sbet_top_tb.sv
// Purpose: Self-checking bench of the sideband error and thermal block.
// Assumes: Inputs change and outputs are read at the falling edge.
// Notes: Reference enable every two clocks, so a pulse lasts 31 or 32 clocks.
`timescale 1ns/100ps
`default_nettype none
module sbet_top_tb;
    import sbet_pkg::*;
    logic i_clk = 1'h0, i_nrst = 1'h0, pg = 1'h0, mc = 1'h0, ie = 1'h0, enh = 1'h1;
    logic mode = 1'h1, sens = 1'h0, pm = 1'h0, io_oe, int_n, machine_check_exception, tca, pms, trist;
    logic [1:0] br = 2'h0;
    logic [2:0] io_n;
    logic [3:0] ext_pull = 4'h0, lvl_n, thr;
    sbet_io_err_type io = 3'h0;
    sbet_od_type fe, ma, mb, po;
    int mismatches = 0, cmp_count = 0, cyc = 0;
    always #2.5 i_clk = ~i_clk;
    sbet_far_end u_sbet_far_end (.i_dev_oe({po.oe, mb.oe, ma.oe, fe.oe}), .i_ext_pull(ext_pull),
        .o_level_n(lvl_n));
    sbet_top u_sbet_top (.i_clk(i_clk), .i_nrst(i_nrst), .i_power_good_in(pg),
        .i_mc_error_event(mc), .i_int_error_event(ie), .i_io_err(io), .i_enh_mc_mode(enh),
        .i_mem_hot_mode_out(mode), .i_branch_overtemp(br), .i_sensor_overtemp(sens),
        .i_power_mgmt_sync_in(pm), .i_fatal_error_line_n(lvl_n[0]),
        .i_memory_hot_pair_a_n(lvl_n[1]), .i_memory_hot_pair_b_n(lvl_n[2]),
        .i_processor_overtemp_line_n(lvl_n[3]), .o_fatal_error_line(fe),
        .o_memory_hot_pair_a(ma), .o_memory_hot_pair_b(mb), .o_processor_overtemp_line(po),
        .o_io_error_n(io_n), .o_io_error_oe(io_oe), .o_machine_check_interrupt_out_n(int_n),
        .o_machine_check_exception(machine_check_exception), .o_throttle_channel(thr),
        .o_thermal_control_active(tca), .o_power_mgmt_status(pms), .o_outputs_tristated(trist));
    task chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            mismatches++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task tick(input int n);
        repeat (n) @(negedge i_clk);
    endtask
    task summarize;
        if (mismatches == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Collects one-cycle exception and interrupt pulses over a window of clocks.
    task watch(input int n, output logic s, output logic q);
        s = 1'h0;
        q = 1'h0;
        repeat (n)
        begin
            s |= machine_check_exception;
            q |= !int_n;
            tick(1);
        end
    endtask
    task t_mc;
        int n, e;
        logic s;
        mc = 1'h1;
        tick(1);
        mc = 1'h0;
        s = machine_check_exception;
        tick(1);
        chk(int_n, 8'h0);
        mc = 1'h1;
        n = 0;
        e = 0;
        repeat (40)
        begin
            n += (fe.oe === 1'h1);
            e += (machine_check_exception === 1'h1);
            tick(1);
            mc = 1'h0;
        end
        chk(s, 8'h1);
        chk(n == 31 || n == 32, 8'h1);
        chk(8'(e), 8'h1);
    endtask
    task t_int;
        ie = 1'h1;
        tick(1);
        ie = 1'h0;
        tick(45);
        chk(fe.oe, 8'h1);
        i_nrst = 1'h0;
        tick(2);
        i_nrst = 1'h1;
        chk(fe.oe, 8'h0);
    endtask
    task t_ext;
        logic s, q;
        pg = 1'h0;
        ext_pull = 4'h1;
        watch(6, s, q);
        chk(s, 8'h0);
        chk(q, 8'h0);
        ext_pull = 4'h0;
        pg = 1'h1;
        enh = 1'h0;
        tick(2);
        ext_pull = 4'h1;
        watch(6, s, q);
        chk(s, 8'h1);
        chk(q, 8'h0);
        ext_pull = 4'h0;
        enh = 1'h1;
        tick(2);
    endtask
    task t_io;
        for (int v = 0; v < 8; v++)
        begin
            io = 3'(v);
            tick(1);
            chk(io_n, {5'h00, ~{io.fatal, io.nonfatal, io.corrected}});
        end
        chk(io_oe, 8'h1);
    endtask
    task t_mem;
        br = 2'h1;
        tick(1);
        chk(lvl_n[2:1], 8'h2);
        br = 2'h2;
        tick(1);
        chk(lvl_n[2:1], 8'h1);
        br = 2'h0;
        tick(1);
        mode = 1'h0;
        ext_pull = 4'h4;
        tick(2);
        chk(thr, 8'hc);
        ext_pull = 4'h2;
        tick(2);
        chk(thr, 8'h3);
        ext_pull = 4'h0;
        mode = 1'h1;
    endtask
    task t_hot;
        sens = 1'h1;
        pm = 1'h1;
        tick(1);
        chk({lvl_n[3], tca, pms}, 8'h3);
        sens = 1'h0;
        pm = 1'h0;
        ext_pull = 4'h8;
        tick(3);
        chk({tca, pms}, 8'h2);
        ext_pull = 4'h0;
        tick(2);
        chk(tca, 8'h0);
    endtask
    task t_tri;
        ext_pull = 4'h8;
        tick(2);
        i_nrst = 1'h0;
        tick(2);
        i_nrst = 1'h1;
        sens = 1'h1;
        br = 2'h3;
        tick(2);
        chk({trist, io_oe, po.oe, fe.oe, ma.oe, mb.oe}, 8'h20);
        ext_pull = 4'h0;
        sens = 1'h0;
        br = 2'h0;
        pg = 1'h0;
        tick(2);
        chk(trist, 8'h0);
        pg = 1'h1;
        tick(2);
    endtask
    always @(posedge i_clk)
    begin
        cyc++;
        if (cyc == 2000)
        begin
            mismatches++;
            summarize;
        end
    end
    initial
    begin
        tick(8);
        pg = 1'h1;
        tick(8);
        i_nrst = 1'h1;
        tick(1);
        t_mc;
        t_int;
        t_ext;
        t_io;
        t_mem;
        t_hot;
        t_tri;
        summarize;
    end
endmodule // sbet_top_tb
`default_nettype wire
